/* File: core/tcc_timer.sv */
// Added by the designer: the address map and the Wishbone slave port.
module tcc_timer #(
    parameter int CNT_W = 16,          // counter width
    parameter int PRE_W = 3            // prescale select width
) (
    input  wire logic        REF_CLK,  // system clock, 40 MHz
    input  wire logic        RST,      // synchronous reset, active high
    input  wire logic        TIMER_IN, // timer input pin
    input  wire logic [7:0]  WB_ADR_I, // wishbone byte address
    input  wire logic [31:0] WB_DAT_I, // wishbone write data
    input  wire logic [3:0]  WB_SEL_I, // wishbone byte selects
    input  wire logic        WB_WE_I,  // wishbone write enable
    input  wire logic        WB_CYC_I, // wishbone cycle
    input  wire logic        WB_STB_I, // wishbone strobe
    output logic [31:0]      WB_DAT_O, // wishbone read data
    output logic             WB_ACK_O, // wishbone acknowledge
    output logic             TMR_IRQ   // interrupt request pulse
);
    import tcc_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (CNT_W != 16) begin : g_bad_cnt
        $error("tcc_timer: counter width must be 16");
    end
    if (PRE_W < 1 || PRE_W > 3) begin : g_bad_pre
        $error("tcc_timer: prescale select width must be 1 to 3");
    end

    localparam int PRE_CNT_W = (1 << PRE_W) - 1;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    tcc_edge_if edge_bus ();

    logic [7:0]           timer_control_one;
    logic [CNT_W-1:0]     count;
    logic [CNT_W-1:0]     reload;
    logic [CNT_W-1:0]     capture;
    logic                 capture_cause_flag;
    logic                 started;
    logic [PRE_CNT_W-1:0] pre_cnt;

    logic                 enabled;
    tcc_mode_t            mode;
    logic [PRE_W-1:0]     pre_sel;
    tcc_irq_cfg_t         interrupt_source_config;

    logic                 req;
    logic                 wr_req;
    logic                 rd_req;
    logic                 wr_ctrl;
    logic                 wr_count;
    logic                 wr_reload;
    logic                 wr_capture;
    logic [31:0]          next_rdata;

    logic                 pre_tick;
    logic                 count_tick;
    logic                 at_reload;
    logic                 cap_event;
    logic                 rld_event;
    logic                 irq_cap_ok;
    logic                 irq_rld_ok;
    logic [CNT_W-1:0]     next_count;
    logic [CNT_W-1:0]     count_wdata;
    logic [CNT_W-1:0]     reload_wdata;
    logic [CNT_W-1:0]     capture_wdata;

    // ------------------------------------------------------------------
    // input edge detector
    // ------------------------------------------------------------------
    tcc_edge u_edge (
        .REF_CLK   (REF_CLK),
        .RST       (RST),
        .TIMER_IN  (TIMER_IN),
        .edge_port (edge_bus.detector)
    );

    // ------------------------------------------------------------------
    // control field decode
    // ------------------------------------------------------------------
    assign enabled = timer_control_one[TCC_CTRL_EN_BIT];
    assign mode    = tcc_mode_t'(timer_control_one[TCC_CTRL_MODE_BIT]);
    assign pre_sel = timer_control_one[TCC_CTRL_PRE_LSB +: PRE_W];
    assign interrupt_source_config =
        tcc_irq_cfg_t'(timer_control_one[TCC_CTRL_CFG_LSB +: 2]);
    assign edge_bus.input_polarity_select =
        timer_control_one[TCC_CTRL_POL_BIT];

    // ------------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------------
    assign req        = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_req     = req & WB_WE_I;
    assign rd_req     = req & ~WB_WE_I;
    assign wr_ctrl    = wr_req && (WB_ADR_I == TCC_CTRL_OFS);
    assign wr_count   = wr_req && (WB_ADR_I == TCC_COUNT_OFS);
    assign wr_reload  = wr_req && (WB_ADR_I == TCC_RELOAD_OFS);
    assign wr_capture = wr_req && (WB_ADR_I == TCC_CAPTURE_OFS);

    // byte-lane merge for the 16-bit registers
    for (genvar b = 0; b < CNT_W / 8; b++) begin : g_lane
        assign count_wdata[b*8 +: 8] = WB_SEL_I[b] ?
            WB_DAT_I[b*8 +: 8] : count[b*8 +: 8];
        assign reload_wdata[b*8 +: 8] = WB_SEL_I[b] ?
            WB_DAT_I[b*8 +: 8] : reload[b*8 +: 8];
        assign capture_wdata[b*8 +: 8] = WB_SEL_I[b] ?
            WB_DAT_I[b*8 +: 8] : capture[b*8 +: 8];
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (WB_ADR_I)
            TCC_CTRL_OFS: begin
                next_rdata[TCC_CTRL_WIDTH-1:0] = timer_control_one;
            end
            TCC_STATUS_OFS: begin
                next_rdata[TCC_STAT_CAUSE_BIT]   = capture_cause_flag;
                next_rdata[TCC_STAT_STARTED_BIT] = started;
                next_rdata[TCC_STAT_LEVEL_BIT]   = edge_bus.level;
            end
            TCC_COUNT_OFS: begin
                next_rdata[CNT_W-1:0] = count;
            end
            TCC_RELOAD_OFS: begin
                next_rdata[CNT_W-1:0] = reload;
            end
            TCC_CAPTURE_OFS: begin
                next_rdata[CNT_W-1:0] = capture;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // bus answer: ack one cycle after the request, then drop
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= req;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            WB_DAT_O <= 32'h00000000;
        end else if (rd_req) begin
            WB_DAT_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // control and reload registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            timer_control_one <= TCC_CTRL_RST;
        end else if (wr_ctrl && WB_SEL_I[0]) begin
            timer_control_one <= WB_DAT_I[TCC_CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            reload <= TCC_RELOAD_RST;
        end else if (wr_reload) begin
            reload <= reload_wdata;
        end
    end

    // ------------------------------------------------------------------
    // start gate: set by the first qualifying edge in either mode;
    // only capture/compare waits on it, counter mode ignores it
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            started <= 1'b0;
        end else if (!enabled) begin
            started <= 1'b0;
        end else if (edge_bus.edge_seen) begin
            started <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // prescaler, only used in capture/compare mode
    // ------------------------------------------------------------------
    assign pre_tick = (pre_cnt ==
        PRE_CNT_W'((1 << pre_sel) - 1));

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pre_cnt <= '0;
        end else if (!enabled || !started || mode == TCC_MODE_COUNT ||
                     pre_tick || cap_event) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    always_comb begin
        count_tick = 1'b0;
        cap_event  = 1'b0;
        unique case (mode)
            TCC_MODE_COUNT: begin
                count_tick = enabled & edge_bus.edge_seen;
            end
            TCC_MODE_CAPCMP: begin
                cap_event  = enabled & started &
                    edge_bus.edge_seen;
                count_tick = enabled & started & pre_tick;
            end
        endcase
    end

    assign at_reload = (count == reload);
    assign rld_event = count_tick & at_reload & ~cap_event;

    assign irq_cap_ok = (interrupt_source_config != TCC_IRQ_RELOAD);
    assign irq_rld_ok = (interrupt_source_config != TCC_IRQ_CAPTURE);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_comb begin
        next_count = count;
        if (cap_event || rld_event) begin
            next_count = TCC_RESTART;
        end else if (count_tick) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            count <= TCC_COUNT_RST;
        end else if (wr_count) begin
            count <= count_wdata;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // capture register and cause flag
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            capture <= TCC_CAPTURE_RST;
        end else if (cap_event) begin
            capture <= count;
        end else if (wr_capture) begin
            capture <= capture_wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            capture_cause_flag <= 1'b0;
        end else if (cap_event) begin
            capture_cause_flag <= 1'b1;
        end else if (rld_event && mode == TCC_MODE_CAPCMP) begin
            capture_cause_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt request pulse
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TMR_IRQ <= 1'b0;
        end else begin
            TMR_IRQ <= (cap_event & irq_cap_ok) |
                       (rld_event & irq_rld_ok);
        end
    end

endmodule : tcc_timer

/* File: core/tcc_pkg.sv */
package tcc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] TCC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] TCC_STATUS_OFS  = 8'h04;
    localparam logic [7:0] TCC_COUNT_OFS   = 8'h08;
    localparam logic [7:0] TCC_RELOAD_OFS  = 8'h0C;
    localparam logic [7:0] TCC_CAPTURE_OFS = 8'h10;

    // ------------------------------------------------------------------
    // timer_control_one field positions
    // ------------------------------------------------------------------
    localparam int TCC_CTRL_EN_BIT   = 0;
    localparam int TCC_CTRL_MODE_BIT = 1;
    localparam int TCC_CTRL_POL_BIT  = 2;
    localparam int TCC_CTRL_PRE_LSB  = 3;
    localparam int TCC_CTRL_CFG_LSB  = 6;
    localparam int TCC_CTRL_WIDTH    = 8;

    // ------------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------------
    localparam int TCC_STAT_CAUSE_BIT   = 0;
    localparam int TCC_STAT_STARTED_BIT = 1;
    localparam int TCC_STAT_LEVEL_BIT   = 2;

    // ------------------------------------------------------------------
    // values after reset and reload values
    // ------------------------------------------------------------------
    localparam logic [7:0]  TCC_CTRL_RST    = 8'h00;
    localparam logic [15:0] TCC_COUNT_RST   = 16'h0000;
    localparam logic [15:0] TCC_RELOAD_RST  = 16'hFFFF;
    localparam logic [15:0] TCC_CAPTURE_RST = 16'h0000;
    localparam logic [15:0] TCC_RESTART     = 16'h0001;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic {
        TCC_MODE_COUNT   = 1'b0,
        TCC_MODE_CAPCMP  = 1'b1
    } tcc_mode_t;

    typedef enum logic [1:0] {
        TCC_IRQ_BOTH     = 2'b00,
        TCC_IRQ_CAPTURE  = 2'b01,
        TCC_IRQ_RELOAD   = 2'b10,
        TCC_IRQ_BOTH_ALT = 2'b11
    } tcc_irq_cfg_t;

endpackage : tcc_pkg

/* File: core/tcc_edge_if.sv */
interface tcc_edge_if;
    logic input_polarity_select;   // 0 rising, 1 falling
    logic edge_seen;               // one-cycle qualifying edge
    logic level;                   // synchronised input level

    modport detector (
        input  input_polarity_select,
        output edge_seen,
        output level
    );

    modport timer (
        output input_polarity_select,
        input  edge_seen,
        input  level
    );
endinterface : tcc_edge_if

/* File: core/tcc_edge.sv */
module tcc_edge (
    input  wire logic REF_CLK,        // system clock
    input  wire logic RST,            // synchronous reset
    input  wire logic TIMER_IN,       // timer input pin
    tcc_edge_if.detector edge_port    // edge towards timer
);
    import tcc_pkg::*;

    logic sync_first;
    logic sync_second;
    logic last_level;

    // ------------------------------------------------------------------
    // two-flop synchroniser and previous sample
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            last_level  <= 1'b0;
        end else begin
            sync_first  <= TIMER_IN;
            sync_second <= sync_first;
            last_level  <= sync_second;
        end
    end

    // one pulse per transition of the chosen polarity
    assign edge_port.edge_seen = edge_port.input_polarity_select ?
        (last_level & ~sync_second) :
        (~last_level & sync_second);
    assign edge_port.level = sync_second;

endmodule : tcc_edge

/* File: test/tcc_src.sv */
module tcc_src (
    input  wire logic clk,  // system clock
    output logic      tin   // timer input pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial tin = 1'b0;

    // ------------------------------------------------------------------
    // pin level change, held long enough to stay under a quarter rate
    // ------------------------------------------------------------------
    task automatic set_level(input logic v);
        @(posedge clk);
        tin <= v;
        repeat (8) @(posedge clk);
    endtask : set_level
endmodule : tcc_src

/* File: test/tcc_timer_asserts.sv */
module tcc_timer_asserts (
    input wire logic        REF_CLK,   // system clock
    input wire logic        RST,       // synchronous reset
    input wire logic        TIMER_IN,  // timer input pin
    input wire logic [7:0]  WB_ADR_I,  // byte address
    input wire logic [31:0] WB_DAT_I,  // write data
    input wire logic [3:0]  WB_SEL_I,  // byte selects
    input wire logic        WB_WE_I,   // write enable
    input wire logic        WB_CYC_I,  // cycle
    input wire logic        WB_STB_I,  // strobe
    input wire logic [31:0] WB_DAT_O,  // read data
    input wire logic        WB_ACK_O,  // acknowledge
    input wire logic        TMR_IRQ    // interrupt request
);
    import tcc_pkg::*;
    logic       en;
    logic       mode;
    logic       last_in;
    logic [7:0] quiet;
    logic       wr_ctrl;

    assign wr_ctrl = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
                     && WB_ADR_I == TCC_CTRL_OFS && WB_SEL_I[0];

    // ------------------------------------------------------------------
    // shadow of enable and mode, and cycles since the pin last moved
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            en <= 1'b0;
            mode <= 1'b0;
        end else if (wr_ctrl) begin
            en <= WB_DAT_I[TCC_CTRL_EN_BIT];
            mode <= WB_DAT_I[TCC_CTRL_MODE_BIT];
        end
    end

    always_ff @(posedge REF_CLK) begin
        last_in <= TIMER_IN;
        if (RST || TIMER_IN != last_in) begin
            quiet <= 8'h00;
        end else if (quiet != 8'hFF) begin
            quiet <= quiet + 8'h01;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O) else $error("ack missing after request");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    unmap_zero_a: assert property (WB_ACK_O && !$past(WB_WE_I)
        && $past(WB_ADR_I) > 8'h10 |-> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (WB_ACK_O && !$past(WB_WE_I)
        |-> WB_DAT_O[31:16] == 16'h0) else $error("upper read bits set");
    dat_hold_a: assert property ($changed(WB_DAT_O)
        |-> WB_ACK_O && !$past(WB_WE_I)) else $error("read data moved");
    irq_off_a: assert property (!en && !$past(en) && !$past(en, 2)
        |-> !TMR_IRQ) else $error("irq while disabled");
    irq_edge_a: assert property (TMR_IRQ && !mode
        |-> quiet < 8'd12) else $error("counter irq without input edge");
endmodule : tcc_timer_asserts

bind tcc_timer tcc_timer_asserts u_tcc_timer_asserts (
    .REF_CLK, .RST, .TIMER_IN, .WB_ADR_I, .WB_DAT_I, .WB_SEL_I, .WB_WE_I,
    .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .TMR_IRQ
);

/* File: test/tcc_timer_test.sv */
module tcc_timer_test;
    import tcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst;
    logic        timer_in;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic [3:0]  lanes;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        tmr_irq;
    logic [31:0] q;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          irq_n       = 0;
    int          b;

    always #12.5 ref_clk = ~ref_clk;

    tcc_timer u_tcc_timer (
        .REF_CLK(ref_clk), .RST(rst), .TIMER_IN(timer_in),
        .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_WE_I(we),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(wb_dat_o),
        .WB_ACK_O(wb_ack_o), .TMR_IRQ(tmr_irq)
    );
    tcc_src u_tcc_src (.clk(ref_clk), .tin(timer_in));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge ref_clk) begin
        cycles++;
        if (tmr_irq === 1'b1) irq_n++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= lanes;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input string s, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(s, e, q);
    endtask : rd

    task automatic edge_pair;
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
        repeat (24) @(posedge ref_clk);
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
    endtask : edge_pair

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(TCC_CTRL_OFS, "ctrl", 32'h0);
        rd(TCC_STATUS_OFS, "status", 32'h0);
        rd(TCC_COUNT_OFS, "count", 32'h0);
        rd(TCC_RELOAD_OFS, "reload", 32'hFFFF);
        rd(TCC_CAPTURE_OFS, "capture", 32'h0);
        wb(8'h20, 1'b1, 32'hAB);
        rd(8'h20, "unmapped", 32'h0);
        wb(TCC_STATUS_OFS, 1'b1, 32'hFF);
        rd(TCC_STATUS_OFS, "status write", 32'h0);
        // single-lane writes: high byte only, ctrl without its lane
        lanes = 4'h2;
        wb(TCC_RELOAD_OFS, 1'b1, 32'h1234);
        wb(TCC_CTRL_OFS, 1'b1, 32'h01);
        lanes = 4'h3;
        rd(TCC_RELOAD_OFS, "reload high lane", 32'h12FF);
        rd(TCC_CTRL_OFS, "ctrl lane", 32'h0);
    endtask : t_reset

    task automatic t_counter;
        wb(TCC_CTRL_OFS, 1'b1, 32'h39);
        u_tcc_src.set_level(1'b1);
        rd(TCC_COUNT_OFS, "rise count", 32'h1);
        u_tcc_src.set_level(1'b0);
        rd(TCC_COUNT_OFS, "fall ignored", 32'h1);
        wb(TCC_CTRL_OFS, 1'b1, 32'h3D);
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
        rd(TCC_COUNT_OFS, "fall count", 32'h2);
        wb(TCC_CTRL_OFS, 1'b1, 32'h3C);
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
        rd(TCC_COUNT_OFS, "disabled count", 32'h2);
        wb(TCC_RELOAD_OFS, 1'b1, 32'h3);
        wb(TCC_CTRL_OFS, 1'b1, 32'h01);
        b = irq_n;
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
        u_tcc_src.set_level(1'b1);
        rd(TCC_COUNT_OFS, "reload count", 32'h1);
        chk("reload irq", 32'(b + 1), 32'(irq_n));
        wb(TCC_CTRL_OFS, 1'b1, 32'h41);
        wb(TCC_COUNT_OFS, 1'b1, 32'h3);
        b = irq_n;
        u_tcc_src.set_level(1'b0);
        u_tcc_src.set_level(1'b1);
        rd(TCC_COUNT_OFS, "quiet reload", 32'h1);
        chk("capture only irq", 32'(b), 32'(irq_n));
        wb(TCC_CTRL_OFS, 1'b1, 32'hC1);
        wb(TCC_COUNT_OFS, 1'b1, 32'h3);
        b = irq_n;
        u_tcc_src.set_level(1'b0);
        u_tcc_src.set_level(1'b1);
        chk("both alt irq", 32'(b + 1), 32'(irq_n));
    endtask : t_counter

    task automatic t_capture;
        u_tcc_src.set_level(1'b0);
        wb(TCC_CTRL_OFS, 1'b1, 32'h02);
        wb(TCC_COUNT_OFS, 1'b1, 32'h1);
        wb(TCC_RELOAD_OFS, 1'b1, 32'hFFFF);
        wb(TCC_CTRL_OFS, 1'b1, 32'h03);
        repeat (20) @(posedge ref_clk);
        rd(TCC_COUNT_OFS, "held count", 32'h1);
        b = irq_n;
        edge_pair();
        wb(TCC_CAPTURE_OFS, 1'b0, 32'h0);
        chk("capture fast", 32'h1, 32'(q >= 40 && q <= 45));
        chk("capture irq", 32'(b + 1), 32'(irq_n));
        rd(TCC_STATUS_OFS, "cause set", 32'h3);
        wb(TCC_CTRL_OFS, 1'b1, 32'h12);
        wb(TCC_COUNT_OFS, 1'b1, 32'h1);
        wb(TCC_CTRL_OFS, 1'b1, 32'h13);
        edge_pair();
        wb(TCC_CAPTURE_OFS, 1'b0, 32'h0);
        chk("capture slow", 32'h1, 32'(q >= 9 && q <= 12));
        wb(TCC_RELOAD_OFS, 1'b1, 32'h10);
        b = irq_n;
        repeat (80) @(posedge ref_clk);
        chk("compare irq", 32'(b + 1), 32'(irq_n));
        rd(TCC_STATUS_OFS, "cause clear", 32'h2);
        wb(TCC_RELOAD_OFS, 1'b1, 32'hFFFF);
        wb(TCC_CTRL_OFS, 1'b1, 32'h93);
        b = irq_n;
        u_tcc_src.set_level(1'b1);
        u_tcc_src.set_level(1'b0);
        chk("reload only irq", 32'(b), 32'(irq_n));
    endtask : t_capture

    initial begin
        rst   <= 1'b1;
        adr   <= 8'h00;
        dat   <= 32'h0;
        sel   <= 4'h0;
        we    <= 1'b0;
        cyc   <= 1'b0;
        stb   <= 1'b0;
        lanes = 4'h3;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_counter();
        t_capture();
        stop_test();
    end
endmodule : tcc_timer_test
